// file: src/hph_pkg.sv
// Purpose: shared constants for the host parallel port handshake
// Assumes: core_clk at 200 MHz
// Notes: times in ps, derived counts in core_clk cycles
package hph_pkg;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int HW_W = 16;
  localparam int WORD_W = 32;
  localparam int CNT_W = 4;
  // Strobe low: 4 periods or 12.5 ns, whichever is longer
  localparam int STB_LOW_MIN_PERIODS = 4;
  localparam int STB_LOW_MIN_PS = 12500;
  localparam int STB_LOW_PS_CYC =
    (STB_LOW_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STB_LOW_MIN_CYC = (STB_LOW_PS_CYC > STB_LOW_MIN_PERIODS) ?
    STB_LOW_PS_CYC : STB_LOW_MIN_PERIODS;
  localparam int STB_HIGH_MIN_CYC = 4;
  // Second half-word valid: 4 periods plus 8 ns, rounded down
  localparam int HALF2_PERIODS = 4;
  localparam int HALF2_FIXED_PS = 8000;
  localparam int HALF2_MAX_CYC =
    (HALF2_PERIODS * CLK_PERIOD_PS + HALF2_FIXED_PS) / CLK_PERIOD_PS;
  // Data release after strobe high, rounded down
  localparam int DATA_REL_PS = 12000;
  localparam int DATA_REL_MAX_CYC = DATA_REL_PS / CLK_PERIOD_PS;
  typedef logic [1:0] hph_access_type;
  localparam hph_access_type ACC_CTRL = 2'h0;
  localparam hph_access_type ACC_DATA_INC = 2'h1;
  localparam hph_access_type ACC_ADDR = 2'h2;
  localparam hph_access_type ACC_DATA = 2'h3;
  localparam logic HALF_FIRST = 1'b0;
  localparam logic HALF_SECOND = 1'b1;
  localparam logic DIR_READ = 1'b1;
  localparam logic [WORD_W-1:0] ADDR_STEP = 32'h4;
  localparam logic [HW_W-1:0] CTRL_RESET = 16'h0;
  // Device pin vector layout
  localparam int PIN_CS = 0;
  localparam int PIN_DSA = 1;
  localparam int PIN_DSB = 2;
  localparam int PIN_AS = 3;
  localparam int PIN_RW = 4;
  localparam int PIN_HW = 5;
  localparam int PIN_ACC = 6;
  localparam int PIN_DATA = 8;
  localparam int PIN_W = 24;
  // Host pin vector layout
  localparam int HPIN_RDY = 0;
  localparam int HPIN_DATA = 1;
  localparam int HPIN_W = 17;
endpackage

// file: src/hph_if.sv
// Purpose: pins between host master and device port
// Assumes: one end drives the data lines at a time
// Notes: undriven data lines read as pulled up
interface hph_if;
  import hph_pkg::*;
  logic hostChipSelectN;
  logic hostDataStrobeA;
  logic hostDataStrobeB;
  logic hostAddrStrobeN;
  hph_access_type accessTypeSelect;
  logic hostReadWrite;
  logic halfwordIdentifier;
  logic hostReadyN;
  logic [HW_W-1:0] hostDataOut;
  logic hostDataOe;
  logic [HW_W-1:0] devDataOut;
  logic devDataOe;
  logic [HW_W-1:0] hostDataBus;
  assign hostDataBus = devDataOe ? devDataOut :
    (hostDataOe ? hostDataOut : '1);
  modport device (
    input hostChipSelectN,
    input hostDataStrobeA,
    input hostDataStrobeB,
    input hostAddrStrobeN,
    input accessTypeSelect,
    input hostReadWrite,
    input halfwordIdentifier,
    input hostDataBus,
    output hostReadyN,
    output devDataOut,
    output devDataOe
  );
  modport host (
    output hostChipSelectN,
    output hostDataStrobeA,
    output hostDataStrobeB,
    output hostAddrStrobeN,
    output accessTypeSelect,
    output hostReadWrite,
    output halfwordIdentifier,
    output hostDataOut,
    output hostDataOe,
    input hostDataBus,
    input hostReadyN
  );
endinterface

// file: src/hph_device_end.sv
// Purpose: device end of the 16-bit host parallel port handshake
// Assumes: host pins asynchronous to core_clk, filtered by 3 flops
// Notes: transfer engine and CPU address writes on the user side
// Operation
// - Strobe is chip select OR data-strobe XNOR
// - Host holds strobe until ready goes low
// - First data read half issues engine request
// - Read ready waits for engine data
// - Write ready waits while write buffer full
// - Address strobe pulses once per strobe
// - Strobe low at least four periods
// - Strobe high at least four periods
// - Selects sampled at address-strobe or strobe fall
// - Data lines driven only during reads
// - Second read half served without new fetch
// - Host address write updates both copies
module hph_device_end (
  input wire logic core_clk,
  input wire logic arst_n,
  hph_if.device pins,
  output logic engReadReq,
  output logic [hph_pkg::WORD_W-1:0] engReadAddr,
  input wire logic engReadDone,
  input wire logic [hph_pkg::WORD_W-1:0] engReadData,
  output logic engWriteReq,
  output logic [hph_pkg::WORD_W-1:0] engWriteAddr,
  output logic [hph_pkg::WORD_W-1:0] engWriteData,
  input wire logic engWriteAccept,
  input wire logic cpuRdAddrWe,
  input wire logic cpuWrAddrWe,
  input wire logic [hph_pkg::WORD_W-1:0] cpuAddrData,
  output logic [hph_pkg::WORD_W-1:0] readAddr,
  output logic [hph_pkg::WORD_W-1:0] writeAddr,
  output logic [hph_pkg::HW_W-1:0] hostCtrl
);
  import hph_pkg::*;

  logic [PIN_W-1:0] pinRaw;
  logic [PIN_W-1:0] sync1_q;
  logic [PIN_W-1:0] sync2_q;
  logic [PIN_W-1:0] sync3_q;
  logic [PIN_W-1:0] pins_q;
  logic [PIN_W-1:0] pinDiff;
  logic compositeHostStrobeN;
  logic stbPrev_q;
  logic asPrev_q;
  logic strobeFall;
  logic strobeRise;
  logic asFall;
  logic addrSeen_q;
  hph_access_type selAcc_q;
  logic selRd_q;
  logic selHw_q;
  hph_access_type curAcc;
  logic curRd;
  logic curHw;
  logic curData;
  logic selData;
  logic rdFetch;
  logic wrCommit;
  logic hostAddrCommit;
  logic dataCommit;
  logic readWait_q;
  logic [WORD_W-1:0] dataReg_q;
  logic [HW_W-1:0] wrStage_q;
  logic [HW_W-1:0] addrStage_q;
  logic [HW_W-1:0] devDataOut_q;
  logic devDataOe_q;
  logic hostReadyN_q;
  logic engReadReq_q;
  logic [WORD_W-1:0] engReadAddr_q;
  logic engWriteReq_q;
  logic [WORD_W-1:0] engWriteAddr_q;
  logic [WORD_W-1:0] engWriteData_q;
  logic [WORD_W-1:0] readAddr_q;
  logic [WORD_W-1:0] writeAddr_q;
  logic [HW_W-1:0] hostCtrl_q;

  function automatic logic [HW_W-1:0] readHalf(
    input hph_access_type acc,
    input logic hw,
    input logic [HW_W-1:0] ctrl,
    input logic [WORD_W-1:0] addr,
    input logic [WORD_W-1:0] data
  );
    logic [WORD_W-1:0] word;
    word = data;
    if (acc == ACC_CTRL) begin
      word = {{HW_W{1'b0}}, ctrl};
    end else if (acc == ACC_ADDR) begin
      word = addr;
    end
    return (hw == HALF_SECOND) ? word[WORD_W-1:HW_W] : word[HW_W-1:0];
  endfunction

  assign pinRaw = {pins.hostDataBus, pins.accessTypeSelect,
    pins.halfwordIdentifier, pins.hostReadWrite, pins.hostAddrStrobeN,
    pins.hostDataStrobeB, pins.hostDataStrobeA, pins.hostChipSelectN};

  // A bit moves only once stages two and three agree
  assign pinDiff = sync2_q ^ sync3_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= '1;
      sync2_q <= '1;
      sync3_q <= '1;
      pins_q <= '1;
    end else begin
      sync1_q <= pinRaw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pins_q <= (sync3_q & ~pinDiff) | (pins_q & pinDiff);
    end
  end

  assign compositeHostStrobeN = pins_q[PIN_CS] |
    ~(pins_q[PIN_DSA] ^ pins_q[PIN_DSB]);
  assign strobeFall = stbPrev_q & ~compositeHostStrobeN;
  assign strobeRise = ~stbPrev_q & compositeHostStrobeN;
  assign asFall = asPrev_q & ~pins_q[PIN_AS];

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stbPrev_q <= 1'b1;
      asPrev_q <= 1'b1;
    end else begin
      stbPrev_q <= compositeHostStrobeN;
      asPrev_q <= pins_q[PIN_AS];
    end
  end

  // Selects come from the address-strobe latch when one was seen
  assign curAcc = addrSeen_q ? selAcc_q : pins_q[PIN_ACC+:2];
  assign curRd = addrSeen_q ? selRd_q : pins_q[PIN_RW];
  assign curHw = addrSeen_q ? selHw_q : pins_q[PIN_HW];
  assign curData = (curAcc == ACC_DATA) || (curAcc == ACC_DATA_INC);
  assign selData = (selAcc_q == ACC_DATA) || (selAcc_q == ACC_DATA_INC);

  // Only the first address-strobe fall per strobe period is taken
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      addrSeen_q <= 1'b0;
      selAcc_q <= ACC_CTRL;
      selRd_q <= DIR_READ;
      selHw_q <= HALF_FIRST;
    end else begin
      if ((asFall || strobeFall) && (!addrSeen_q || strobeRise)) begin
        selAcc_q <= pins_q[PIN_ACC+:2];
        selRd_q <= pins_q[PIN_RW];
        selHw_q <= pins_q[PIN_HW];
      end
      if (asFall) begin
        addrSeen_q <= 1'b1;
      end else if (strobeRise) begin
        addrSeen_q <= 1'b0;
      end
    end
  end

  assign rdFetch = strobeFall && curRd && curData && curHw == HALF_FIRST;
  assign wrCommit = strobeRise && selRd_q != DIR_READ;
  assign hostAddrCommit = wrCommit && selAcc_q == ACC_ADDR &&
    selHw_q == HALF_SECOND;
  assign dataCommit = wrCommit && selData && selHw_q == HALF_SECOND;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      engReadReq_q <= 1'b0;
      engReadAddr_q <= '0;
      readWait_q <= 1'b0;
      dataReg_q <= '0;
    end else begin
      engReadReq_q <= rdFetch;
      if (rdFetch) begin
        engReadAddr_q <= readAddr_q;
        readWait_q <= 1'b1;
      end else if (readWait_q && engReadDone) begin
        readWait_q <= 1'b0;
        dataReg_q <= engReadData;
      end
    end
  end

  // Ready idles high; it drops when the access can complete
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hostReadyN_q <= 1'b1;
      devDataOe_q <= 1'b0;
      devDataOut_q <= '0;
    end else if (strobeRise) begin
      hostReadyN_q <= 1'b1;
      devDataOe_q <= 1'b0;
    end else if (strobeFall) begin
      devDataOe_q <= curRd;
      devDataOut_q <= readHalf(curAcc, curHw, hostCtrl_q, readAddr_q,
        dataReg_q);
      if (rdFetch) begin
        hostReadyN_q <= 1'b1;
      end else if (!curRd && curData) begin
        hostReadyN_q <= engWriteReq_q;
      end else begin
        hostReadyN_q <= 1'b0;
      end
    end else if (readWait_q && engReadDone) begin
      hostReadyN_q <= 1'b0;
      devDataOut_q <= engReadData[HW_W-1:0];
    end else if (!stbPrev_q && !selRd_q && selData) begin
      hostReadyN_q <= engWriteReq_q;
    end
  end

  // Write data is taken at the strobe rise, as the host holds it there
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrStage_q <= '0;
      addrStage_q <= '0;
      hostCtrl_q <= CTRL_RESET;
    end else if (wrCommit && selHw_q == HALF_FIRST) begin
      if (selAcc_q == ACC_ADDR) begin
        addrStage_q <= pins_q[PIN_DATA+:HW_W];
      end else if (selAcc_q == ACC_CTRL) begin
        hostCtrl_q <= pins_q[PIN_DATA+:HW_W];
      end else begin
        wrStage_q <= pins_q[PIN_DATA+:HW_W];
      end
    end
  end

  // One-word write buffer; a new word wins over a same-cycle accept
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      engWriteReq_q <= 1'b0;
      engWriteAddr_q <= '0;
      engWriteData_q <= '0;
    end else begin
      if (engWriteAccept) begin
        engWriteReq_q <= 1'b0;
      end
      if (dataCommit) begin
        engWriteReq_q <= 1'b1;
        engWriteAddr_q <= writeAddr_q;
        engWriteData_q <= {pins_q[PIN_DATA+:HW_W], wrStage_q};
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      readAddr_q <= '0;
      writeAddr_q <= '0;
    end else if (hostAddrCommit) begin
      readAddr_q <= {pins_q[PIN_DATA+:HW_W], addrStage_q};
      writeAddr_q <= {pins_q[PIN_DATA+:HW_W], addrStage_q};
    end else begin
      if (cpuRdAddrWe) begin
        readAddr_q <= cpuAddrData;
      end else if (rdFetch && curAcc == ACC_DATA_INC) begin
        readAddr_q <= readAddr_q + ADDR_STEP;
      end
      if (cpuWrAddrWe) begin
        writeAddr_q <= cpuAddrData;
      end else if (dataCommit && selAcc_q == ACC_DATA_INC) begin
        writeAddr_q <= writeAddr_q + ADDR_STEP;
      end
    end
  end

  assign pins.hostReadyN = hostReadyN_q;
  assign pins.devDataOut = devDataOut_q;
  assign pins.devDataOe = devDataOe_q;
  assign engReadReq = engReadReq_q;
  assign engReadAddr = engReadAddr_q;
  assign engWriteReq = engWriteReq_q;
  assign engWriteAddr = engWriteAddr_q;
  assign engWriteData = engWriteData_q;
  assign readAddr = readAddr_q;
  assign writeAddr = writeAddr_q;
  assign hostCtrl = hostCtrl_q;
endmodule

// file: src/hph_host_end.sv
// Purpose: host master end of the 16-bit parallel port handshake
// Assumes: ready and data pins filtered by 3 flops
// Notes: each command is two half-word accesses, low half first
module hph_host_end (
  input wire logic core_clk,
  input wire logic arst_n,
  hph_if.host pins,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire hph_pkg::hph_access_type cmdAccess,
  input wire logic cmdRead,
  input wire logic [hph_pkg::WORD_W-1:0] cmdWord,
  input wire logic useAddrStrobe,
  output logic rspValid,
  output logic [hph_pkg::WORD_W-1:0] rspWord
);
  import hph_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_LOW = 4'b0100,
    ST_HIGH = 4'b1000
  } hph_host_state_type;

  hph_host_state_type state_q;
  logic [HPIN_W-1:0] sync1_q;
  logic [HPIN_W-1:0] sync2_q;
  logic [HPIN_W-1:0] sync3_q;
  logic [HPIN_W-1:0] pin_q;
  logic [HPIN_W-1:0] pinDiff;
  logic [CNT_W-1:0] cnt_q;
  logic half_q;
  logic useAs_q;
  logic cmdReady_q;
  logic rspValid_q;
  logic [WORD_W-1:0] word_q;
  hph_access_type acc_q;
  logic rd_q;
  logic chipSelN_q;
  logic strobeA_q;
  logic addrStrobeN_q;
  logic dataOe_q;
  logic [HW_W-1:0] dataOut_q;
  logic lowDone;
  logic highDone;

  assign pinDiff = sync2_q ^ sync3_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= '1;
      sync2_q <= '1;
      sync3_q <= '1;
      pin_q <= '1;
    end else begin
      sync1_q <= {pins.hostDataBus, pins.hostReadyN};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pin_q <= (sync3_q & ~pinDiff) | (pin_q & pinDiff);
    end
  end

  assign lowDone = cnt_q >= CNT_W'(STB_LOW_MIN_CYC) &&
    !pin_q[HPIN_RDY];
  // Waiting for ready high keeps a stale low from ending the next access
  assign highDone = cnt_q >= CNT_W'(STB_HIGH_MIN_CYC - 1) &&
    pin_q[HPIN_RDY];

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      half_q <= HALF_FIRST;
      cmdReady_q <= 1'b1;
      rspValid_q <= 1'b0;
      word_q <= '0;
      acc_q <= ACC_CTRL;
      rd_q <= DIR_READ;
      useAs_q <= 1'b0;
      chipSelN_q <= 1'b1;
      strobeA_q <= 1'b1;
      addrStrobeN_q <= 1'b1;
      dataOe_q <= 1'b0;
      dataOut_q <= '0;
    end else begin
      rspValid_q <= 1'b0;
      if (cnt_q != '1) begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
      case (state_q)
        ST_IDLE: begin
          if (cmdValid) begin
            cmdReady_q <= 1'b0;
            word_q <= cmdWord;
            acc_q <= cmdAccess;
            rd_q <= cmdRead;
            useAs_q <= useAddrStrobe;
            half_q <= HALF_FIRST;
            state_q <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          chipSelN_q <= 1'b0;
          dataOe_q <= !rd_q;
          dataOut_q <= (half_q == HALF_SECOND) ?
            word_q[WORD_W-1:HW_W] : word_q[HW_W-1:0];
          addrStrobeN_q <= !useAs_q;
          state_q <= ST_LOW;
          cnt_q <= '0;
        end
        ST_LOW: begin
          strobeA_q <= 1'b0;
          if (strobeA_q == 1'b0) begin
            addrStrobeN_q <= 1'b1;
          end
          if (lowDone && strobeA_q == 1'b0) begin
            if (rd_q) begin
              if (half_q == HALF_SECOND) begin
                word_q[WORD_W-1:HW_W] <= pin_q[HPIN_DATA+:HW_W];
              end else begin
                word_q[HW_W-1:0] <= pin_q[HPIN_DATA+:HW_W];
              end
            end
            strobeA_q <= 1'b1;
            chipSelN_q <= 1'b1;
            cnt_q <= '0;
            state_q <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (highDone) begin
            dataOe_q <= 1'b0;
            if (half_q == HALF_FIRST) begin
              half_q <= HALF_SECOND;
              state_q <= ST_SETUP;
            end else begin
              rspValid_q <= 1'b1;
              cmdReady_q <= 1'b1;
              state_q <= ST_IDLE;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
          cmdReady_q <= 1'b1;
        end
      endcase
    end
  end

  assign pins.hostChipSelectN = chipSelN_q;
  assign pins.hostDataStrobeA = strobeA_q;
  assign pins.hostDataStrobeB = 1'b1;
  assign pins.hostAddrStrobeN = addrStrobeN_q;
  assign pins.accessTypeSelect = acc_q;
  assign pins.hostReadWrite = rd_q;
  assign pins.halfwordIdentifier = half_q;
  assign pins.hostDataOut = dataOut_q;
  assign pins.hostDataOe = dataOe_q;
  assign cmdReady = cmdReady_q;
  assign rspValid = rspValid_q;
  assign rspWord = word_q;
endmodule

// file: dv/hph_link_chk.sv
// Purpose: pin-level checks on the link between host and device ends
// Assumes: every pin is a flop output on core_clk
// Notes: composite strobe is rebuilt here from the raw pins
module hph_link_chk (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic hostChipSelectN,
  input wire logic hostDataStrobeA,
  input wire logic hostDataStrobeB,
  input wire logic hostAddrStrobeN,
  input wire hph_pkg::hph_access_type accessTypeSelect,
  input wire logic hostReadWrite,
  input wire logic halfwordIdentifier,
  input wire logic hostReadyN,
  input wire logic hostDataOe,
  input wire logic devDataOe
);
  import hph_pkg::*;
  localparam int QUICK_MAX = HALF2_MAX_CYC;
  logic stbN;
  logic [1:0] asCount_q;
  assign stbN = hostChipSelectN | ~(hostDataStrobeA ^ hostDataStrobeB);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // Address strobe falls since the last strobe release, saturating
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      asCount_q <= 2'h0;
    end else if ($rose(stbN)) begin
      asCount_q <= 2'h0;
    end else if ($fell(hostAddrStrobeN) && asCount_q != 2'h3) begin
      asCount_q <= asCount_q + 2'h1;
    end
  end
  property p_ready_needs_stb;
    $fell(hostReadyN) |-> !stbN;
  endproperty
  a_ready_needs_stb: assert property (p_ready_needs_stb)
    else $error("ready went low without an active strobe");
  property p_hold_to_ready;
    $rose(stbN) |-> !$past(hostReadyN);
  endproperty
  a_hold_to_ready: assert property (p_hold_to_ready)
    else $error("strobe released before ready");
  property p_low_min;
    $fell(stbN) |=> !stbN [*3];
  endproperty
  a_low_min: assert property (p_low_min)
    else $error("strobe low too short");
  property p_high_min;
    $rose(stbN) |=> stbN [*3];
  endproperty
  a_high_min: assert property (p_high_min)
    else $error("strobe high too short");
  property p_as_once;
    asCount_q <= 2'h1;
  endproperty
  a_as_once: assert property (p_as_once)
    else $error("address strobe pulsed twice in one access");
  property p_quick_ready;
    $fell(stbN) && (accessTypeSelect == ACC_CTRL ||
      accessTypeSelect == ACC_ADDR || (hostReadWrite == DIR_READ &&
      halfwordIdentifier == HALF_SECOND)) |-> ##[1:QUICK_MAX] !hostReadyN;
  endproperty
  a_quick_ready: assert property (p_quick_ready)
    else $error("ready late on an access needing no fetch");
  property p_drive_read;
    devDataOe |-> hostReadWrite == DIR_READ;
  endproperty
  a_drive_read: assert property (p_drive_read)
    else $error("device drove data on a write");
  property p_drive_start;
    $rose(devDataOe) |-> !stbN;
  endproperty
  a_drive_start: assert property (p_drive_start)
    else $error("device drove data outside the strobe");
  property p_release;
    stbN [*7] |-> hostReadyN && !devDataOe;
  endproperty
  a_release: assert property (p_release)
    else $error("ready or data drive held after strobe release");
  property p_no_clash;
    !(devDataOe && hostDataOe);
  endproperty
  a_no_clash: assert property (p_no_clash)
    else $error("both ends drive the data lines");
endmodule

// file: dv/tb_top.sv
// Purpose: both ends joined, user sides driven and judged
// Assumes: engine and CPU address side modelled by the bench
// Notes: read data from the engine is the address xor a mask
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import hph_pkg::*;
  localparam logic [WORD_W-1:0] RD_MASK = 32'ha5a5_0f0f;
  localparam int TIMEOUT_CYC = 20000;
  logic core_clk, arst_n, cmdValid, cmdReady, cmdRead, useAddrStrobe;
  hph_access_type cmdAccess;
  logic [WORD_W-1:0] cmdWord, rspWord, engReadAddr, engReadData;
  logic [WORD_W-1:0] engWriteAddr, engWriteData, cpuAddrData;
  logic [WORD_W-1:0] readAddr, writeAddr, rdAddrSeen, r;
  logic [HW_W-1:0] hostCtrl;
  logic rspValid, engReadReq, engReadDone, engWriteReq, engWriteAccept;
  logic cpuRdAddrWe, cpuWrAddrWe, wrStall, rdWait, rdEarly;
  logic [WORD_W-1:0] wrAddrQ[$], wrDataQ[$];
  int fail_count, checks_done, cycles, engDelay, rdReqs;
  realtime relTime;
  hph_if link();
  hph_device_end hph_device_end_inst (.core_clk(core_clk),
    .arst_n(arst_n), .pins(link), .engReadReq(engReadReq),
    .engReadAddr(engReadAddr), .engReadDone(engReadDone),
    .engReadData(engReadData), .engWriteReq(engWriteReq),
    .engWriteAddr(engWriteAddr), .engWriteData(engWriteData),
    .engWriteAccept(engWriteAccept), .cpuRdAddrWe(cpuRdAddrWe),
    .cpuWrAddrWe(cpuWrAddrWe), .cpuAddrData(cpuAddrData),
    .readAddr(readAddr), .writeAddr(writeAddr), .hostCtrl(hostCtrl));
  hph_host_end hph_host_end_inst (.core_clk(core_clk), .arst_n(arst_n),
    .pins(link), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdAccess(cmdAccess), .cmdRead(cmdRead), .cmdWord(cmdWord),
    .useAddrStrobe(useAddrStrobe), .rspValid(rspValid),
    .rspWord(rspWord));
  hph_link_chk hph_link_chk_inst (.core_clk(core_clk), .arst_n(arst_n),
    .hostChipSelectN(link.hostChipSelectN),
    .hostDataStrobeA(link.hostDataStrobeA),
    .hostDataStrobeB(link.hostDataStrobeB),
    .hostAddrStrobeN(link.hostAddrStrobeN),
    .accessTypeSelect(link.accessTypeSelect),
    .hostReadWrite(link.hostReadWrite),
    .halfwordIdentifier(link.halfwordIdentifier),
    .hostReadyN(link.hostReadyN), .hostDataOe(link.hostDataOe),
    .devDataOe(link.devDataOe));
  always #2.5 core_clk = ~core_clk;
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask
  task automatic check(input logic [WORD_W-1:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == TIMEOUT_CYC) begin
      fail_count++;
      report_and_stop();
    end
  end
  // Engine read side: fetch answered after engDelay cycles
  always begin
    @(posedge core_clk);
    if (engReadReq === 1'b1) begin
      rdReqs++;
      rdAddrSeen = engReadAddr;
      rdWait = 1'b1;
      repeat (engDelay) @(posedge core_clk);
      #1;
      engReadData = rdAddrSeen ^ RD_MASK;
      engReadDone = 1'b1;
      rdWait = 1'b0;
      tick();
      engReadDone = 1'b0;
    end
  end
  always @(posedge core_clk) begin
    if (rdWait && link.hostReadyN === 1'b0) rdEarly = 1'b1;
  end
  // Engine write side: buffer drained only while not stalled
  always begin
    @(posedge core_clk);
    if (engWriteReq === 1'b1 && !wrStall) begin
      wrAddrQ.push_back(engWriteAddr);
      wrDataQ.push_back(engWriteData);
      #1;
      engWriteAccept = 1'b1;
      tick();
      engWriteAccept = 1'b0;
    end
  end
  task automatic do_cmd(input hph_access_type acc, input logic rd,
      input logic [WORD_W-1:0] w, input logic as);
    int n;
    cmdAccess = acc;
    cmdRead = rd;
    cmdWord = w;
    useAddrStrobe = as;
    cmdValid = 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (cmdReady !== 1'b1 && n < 2000);
    #1;
    cmdValid = 1'b0;
    do begin
      @(posedge core_clk);
      n++;
    end while (rspValid !== 1'b1 && n < 2000);
    r = rspWord;
    if (n >= 2000) check(32'h0, 32'h1);
    #1;
  endtask
  task automatic t_reset();
    check({31'h0, link.hostReadyN}, 32'h1);
    check({31'h0, link.devDataOe}, 32'h0);
    check({16'h0, link.hostDataBus}, 32'hffff);
    check({31'h0, cmdReady}, 32'h1);
    check({16'h0, hostCtrl}, 32'h0);
    check(readAddr, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_ctrl();
    do_cmd(ACC_CTRL, 1'b0, 32'h1234_1234, 1'b0);
    check({16'h0, hostCtrl}, 32'h1234);
    do_cmd(ACC_CTRL, 1'b1, 32'h0, 1'b1);
    check(r, 32'h0000_1234);
    $display("control test done");
  endtask
  task automatic t_addr();
    do_cmd(ACC_ADDR, 1'b0, 32'h0000_0100, 1'b1);
    check(readAddr, 32'h100);
    check(writeAddr, 32'h100);
    cpuAddrData = 32'h500;
    cpuRdAddrWe = 1'b1;
    tick();
    cpuRdAddrWe = 1'b0;
    cpuAddrData = 32'h600;
    cpuWrAddrWe = 1'b1;
    tick();
    cpuWrAddrWe = 1'b0;
    tick();
    check(readAddr, 32'h500);
    check(writeAddr, 32'h600);
    do_cmd(ACC_ADDR, 1'b1, 32'h0, 1'b0);
    check(r, 32'h500);
    $display("address test done");
  endtask
  task automatic t_write();
    int i;
    do_cmd(ACC_ADDR, 1'b0, 32'h200, 1'b0);
    wrStall = 1'b1;
    do_cmd(ACC_DATA_INC, 1'b0, 32'hcafe_0001, 1'b1);
    check(r, 32'hcafe_0001);
    check(writeAddr, 32'h204);
    // Far future until the drain is really released
    relTime = 1.0e9;
    fork
      begin
        repeat (300) tick();
        relTime = $realtime;
        wrStall = 1'b0;
      end
    join_none
    // Buffer full: the second write must wait for the drain
    do_cmd(ACC_DATA_INC, 1'b0, 32'hcafe_0002, 1'b0);
    check({31'h0, $realtime > relTime}, 32'h1);
    do_cmd(ACC_DATA, 1'b0, 32'hcafe_0003, 1'b1);
    check(writeAddr, 32'h208);
    for (i = 0; i < 100 && wrAddrQ.size() < 3; i++) tick();
    check(wrAddrQ.size(), 32'h3);
    for (i = 0; i < 3; i++) begin
      check(wrAddrQ[i], 32'h200 + 32'h4 * i);
      check(wrDataQ[i], 32'hcafe_0001 + i);
    end
    $display("write test done");
  endtask
  task automatic t_read();
    int i;
    do_cmd(ACC_ADDR, 1'b0, 32'h400, 1'b0);
    engDelay = 30;
    rdReqs = 0;
    rdEarly = 1'b0;
    do_cmd(ACC_DATA, 1'b1, 32'h0, 1'b0);
    check(r, 32'h400 ^ RD_MASK);
    check(rdReqs, 32'h1);
    check(rdAddrSeen, 32'h400);
    check({31'h0, rdEarly}, 32'h0);
    engDelay = 2;
    for (i = 0; i < 2; i++) begin
      do_cmd(ACC_DATA_INC, 1'b1, 32'h0, 1'b1);
      check(rdAddrSeen, 32'h400 + 32'h4 * i);
      check(r, (32'h400 + 32'h4 * i) ^ RD_MASK);
    end
    check(rdReqs, 32'h3);
    check(readAddr, 32'h408);
    $display("read test done");
  endtask
  initial begin
    core_clk = 1'b0;
    arst_n = 1'b0;
    cmdValid = 1'b0;
    cmdAccess = ACC_CTRL;
    cmdRead = 1'b0;
    cmdWord = 32'h0;
    useAddrStrobe = 1'b0;
    engReadDone = 1'b0;
    engReadData = 32'h0;
    engWriteAccept = 1'b0;
    cpuRdAddrWe = 1'b0;
    cpuWrAddrWe = 1'b0;
    cpuAddrData = 32'h0;
    wrStall = 1'b0;
    rdWait = 1'b0;
    rdEarly = 1'b0;
    engDelay = 2;
    relTime = 0;
    repeat (8) @(posedge core_clk);
    #1;
    arst_n = 1'b1;
    t_reset();
    t_ctrl();
    t_addr();
    t_write();
    t_read();
    report_and_stop();
  end
endmodule
